// *** src/mod_pkg.sv ***
package mod_pkg;
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int TARGET_BIT = 7;
  localparam int LIT_HI = 7;
  localparam int FIELD_HI = 13;
  localparam int FIELD_LO = 8;
  // upper six bits of the instruction word per opcode, upper four for the literal load
  localparam logic [5:0] OP_OR_REG = 6'h04;
  localparam logic [5:0] OP_COPY_REG = 6'h08;
  localparam logic [5:0] OP_STORE_ACC = 6'h00;
  localparam logic [3:0] OP_LOAD_LIT_HI = 4'hC;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;

  typedef enum logic [1:0] {
    MOD_IDLE  = 2'b00,
    MOD_WRITE = 2'b01
  } mod_state_t;

  typedef struct packed {
    logic              valid;
    logic [INSN_W-1:0] word;
  } mod_insn_t;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mod_wr_t;
endpackage

// *** src/mod_decode.sv ***
`timescale 1ns/100ps
module mod_decode
  import mod_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire logic                clk_en,
  // instruction stream
  input  wire mod_insn_t           insn,
  output logic                     insn_ready,
  // register file
  output logic [ADDR_W-1:0]        rd_addr,
  input  wire logic [DATA_W-1:0]   rd_data,
  output mod_wr_t                  wr,
  // core state
  output logic [DATA_W-1:0]        accumulator_reg,
  output logic                     result_null_flag,
  output logic                     decode_hit
);

  // opcode recognisers, shared by the datapath and the hit flag
  function automatic logic is_or_op(
    input logic [INSN_W-1:0] w
  );
    return w[FIELD_HI:FIELD_LO] == OP_OR_REG;
  endfunction

  function automatic logic is_copy_op(
    input logic [INSN_W-1:0] w
  );
    return w[FIELD_HI:FIELD_LO] == OP_COPY_REG;
  endfunction

  // store form has the target bit forced high; low target is another op
  function automatic logic is_store_op(
    input logic [INSN_W-1:0] w
  );
    return (w[FIELD_HI:FIELD_LO] == OP_STORE_ACC) & w[TARGET_BIT];
  endfunction

  // only the top four bits are compared, so the don't-cares never matter
  function automatic logic is_load_lit(
    input logic [INSN_W-1:0] w
  );
    return w[FIELD_HI:FIELD_LO+2] == OP_LOAD_LIT_HI;
  endfunction

  function automatic logic is_known_op(
    input logic [INSN_W-1:0] w
  );
    return is_or_op(w) | is_copy_op(w) | is_store_op(w)
           | is_load_lit(w);
  endfunction

  // instruction fields
  wire logic [INSN_W-1:0] word;
  wire logic              take;
  wire logic              result_target_bit;
  wire logic [ADDR_W-1:0] file_addr;
  wire logic [DATA_W-1:0] lit_value;

  assign word              = insn.word;
  assign take              = insn.valid & clk_en;
  assign result_target_bit = word[TARGET_BIT];
  assign file_addr         = word[ADDR_W-1:0];
  assign lit_value         = word[LIT_HI:0];

  // opcode classes
  wire logic is_or;
  wire logic is_copy;
  wire logic is_store;
  wire logic is_lit;
  wire logic alu_op;
  wire logic known_op;

  assign is_or    = is_or_op(word);
  assign is_copy  = is_copy_op(word);
  assign is_store = is_store_op(word);
  assign is_lit   = is_load_lit(word);
  assign alu_op   = is_or | is_copy;
  assign known_op = is_known_op(word);

  // datapath
  wire logic [DATA_W-1:0] or_result;
  wire logic [DATA_W-1:0] any_set;
  wire logic [DATA_W-1:0] alu_result;
  wire logic              alu_zero;

  genvar gi;
  genvar gj;

  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_or_bit
      assign or_result[gi] = accumulator_reg[gi] | rd_data[gi];
    end
  endgenerate

  // copy passes the read value straight through
  assign alu_result = is_or ? or_result : rd_data;

  // an or-chain over the result tells zero; bit 0 seeds it
  assign any_set[0] = alu_result[0];
  generate
    for (gj = 1; gj < DATA_W; gj++) begin : g_zero_chain
      assign any_set[gj] = any_set[gj-1] | alu_result[gj];
    end
  endgenerate
  assign alu_zero = ~any_set[DATA_W-1];

  // destination routing
  wire logic              to_acc;
  wire logic              to_reg;
  wire logic              acc_from_alu;
  wire logic              acc_from_lit;
  wire logic              flag_load;
  wire logic              wr_load;
  wire logic [DATA_W-1:0] wr_value;

  assign to_acc       = alu_op & ~result_target_bit;
  assign to_reg       = (alu_op & result_target_bit) | is_store;
  assign acc_from_alu = take & to_acc;
  assign acc_from_lit = take & is_lit;
  assign flag_load    = take & alu_op;
  assign wr_load      = take & to_reg;
  assign wr_value     = is_store ? accumulator_reg : alu_result;

  // next-state values
  logic [DATA_W-1:0] next_acc;
  logic              next_zero;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [DATA_W-1:0] next_wr_data;
  logic              next_hit;

  // literal and register ops never share a word, so the order is free
  assign next_acc     = acc_from_lit ? lit_value
                      : acc_from_alu ? alu_result
                      : accumulator_reg;
  assign next_zero    = flag_load ? alu_zero : result_null_flag;
  assign next_wr_addr = wr_load ? file_addr : '0;
  assign next_wr_data = wr_load ? wr_value : '0;
  assign next_hit     = take & known_op;

  // write stage
  mod_state_t        wr_state;
  mod_state_t        next_wr_state;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [DATA_W-1:0] wr_data_q;

  always_comb begin
    next_wr_state = MOD_IDLE;
    case (wr_state)
      MOD_IDLE: begin
        next_wr_state = wr_load ? MOD_WRITE : MOD_IDLE;
      end
      // a new write may follow the last one straight away
      MOD_WRITE: begin
        next_wr_state = wr_load ? MOD_WRITE : MOD_IDLE;
      end
      default: begin
        next_wr_state = MOD_IDLE;
      end
    endcase
  end

  // the pulse comes from the state flop, address and data from their own
  assign wr = {wr_state == MOD_WRITE, wr_addr_q, wr_data_q};

  // the register file reads combinationally, so every op is single cycle
  assign insn_ready = clk_en;
  assign rd_addr    = file_addr;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      accumulator_reg <= ACC_RESET;
    end else if (clk_en) begin
      accumulator_reg <= next_acc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      result_null_flag <= ZERO_RESET;
    end else if (clk_en) begin
      result_null_flag <= next_zero;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_state <= MOD_IDLE;
    end else if (clk_en) begin
      wr_state <= next_wr_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else if (clk_en) begin
      wr_addr_q <= next_wr_addr;
      wr_data_q <= next_wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      decode_hit <= 1'b0;
    end else if (clk_en) begin
      decode_hit <= next_hit;
    end
  end
endmodule

// *** verification/mod_monitor.sv ***
`timescale 1ns/100ps
module mod_monitor
  import mod_pkg::*;
(
  // clock and control
  input wire logic              ref_clk,
  input wire logic              resetn,
  input wire logic              clk_en,
  // watched ports
  input wire mod_insn_t         insn,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic [DATA_W-1:0] accumulator_reg,
  input wire logic              result_null_flag,
  input wire logic              decode_hit,
  input wire mod_wr_t           wr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // opcode field reads zero whenever nothing is taken
  wire logic [6:0]        op = insn.word[13:7] & {7{clk_en & insn.valid}};
  wire logic [DATA_W-1:0] a  = accumulator_reg;
  wire logic [DATA_W-1:0] r  = rd_data;
  property p_mv;
    op == 7'h10 |=> a == $past(r);
  endproperty
  a_mv: assert property (p_mv) else $error("copy");
  property p_wb;
    op == 7'h11 |=> wr.we && wr.data == $past(r);
  endproperty
  a_wb: assert property (p_wb) else $error("copy back");
  property p_z;
    op[6:1] == 6'h08 |=> result_null_flag == ($past(r) == 8'h00);
  endproperty
  a_z: assert property (p_z) else $error("zero flag");
  property p_lit;
    op[6:3] == 4'hC |=> a == $past(insn.word[7:0]);
  endproperty
  a_lit: assert property (p_lit) else $error("literal");
  property p_hit;
    op[6:3] == 4'hC |=> decode_hit;
  endproperty
  a_hit: assert property (p_hit) else $error("literal missed");
  property p_or;
    op == 7'h08 |=> a == ($past(a) | $past(r));
  endproperty
  a_or: assert property (p_or) else $error("or");
  property p_orw;
    op == 7'h09 |=> wr.we && wr.data == ($past(a) | $past(r));
  endproperty
  a_orw: assert property (p_orw) else $error("or write back");
endmodule
bind mod_decode mod_monitor mon (.*);

// *** verification/mod_fetch.sv ***
`timescale 1ns/100ps
module mod_fetch
  import mod_pkg::*;
(
  // clock
  input  wire logic        ref_clk,
  // random draw from the bench
  input  wire logic [11:0] rnd,
  // instruction stream
  output mod_insn_t        insn
);
  logic [INSN_W-1:0] word;
  // rnd[11] sets the literal don't-cares, which a code generator never
  // does; elsewhere it picks the store or an opcode that must do nothing
  assign word = rnd[9] ? {4'hC, {2{rnd[11]}}, rnd[7:0]}
    : rnd[11] ? {5'h00, rnd[8], 1'b1, rnd[6:0]}
    : {2'b00, rnd[8], !rnd[8], 2'b00, rnd[7:0]};
  always_ff @(posedge ref_clk) begin
    insn <= {|rnd[10:9], word};
  end
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/100ps
module testbench import mod_pkg::*;;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        clk_en = 1'b0;
  logic [7:0]  rd_data = 8'h00;
  logic [11:0] rnd = 12'h000;
  logic [7:0]  ea;
  logic        ez;
  logic        ehit;
  mod_wr_t     ewr;
  int          seed = 32'h4D91;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;
  mod_insn_t   insn;
  logic [7:0]  acc;
  logic        zf;
  logic        hit;
  logic        rdy;
  logic [6:0]  ra;
  mod_wr_t     wr_o;
  // literal with don't-cares set, copy back, or, store
  logic [20:0] corner [4] = '{{1'b1, 12'hA5A, 8'h00},
                              {1'b1, 12'h585, 8'h00},
                              {1'b1, 12'h405, 8'h00},
                              {1'b1, 12'hC05, 8'h13}};
  mod_fetch fetch (
    .ref_clk (ref_clk),
    .rnd     (rnd),
    .insn    (insn)
  );
  mod_decode uut (
    .ref_clk          (ref_clk),
    .resetn           (resetn),
    .clk_en           (clk_en),
    .insn             (insn),
    .insn_ready       (rdy),
    .rd_addr          (ra),
    .rd_data          (rd_data),
    .wr               (wr_o),
    .accumulator_reg  (acc),
    .result_null_flag (zf),
    .decode_hit       (hit)
  );
  initial forever #2 ref_clk = ~ref_clk;
  function automatic logic [7:0] nx(logic [13:0] w);
    return w[13:10] == 4'hC ? w[7:0] : w[13:7] == 7'h10 ? rd_data
      : w[13:7] == 7'h08 ? ea | rd_data : ea;
  endfunction
  function automatic logic nz(logic [13:0] w);
    return w[13:8] == 6'h04 ? (ea | rd_data) == 8'h00
      : w[13:8] == 6'h08 ? rd_data == 8'h00 : ez;
  endfunction
  function automatic mod_wr_t nw(logic [13:0] w);
    return !w[7] ? 16'h0000 : w[13:8] == 6'h04 ? {1'b1, w[6:0], ea | rd_data}
      : w[13:8] == 6'h08 ? {1'b1, w[6:0], rd_data}
      : w[13:8] == 6'h00 ? {1'b1, w[6:0], ea} : 16'h0000;
  endfunction
  function automatic logic nh(logic [13:0] w);
    return w[13:10] == 4'hC || w[13:8] == 6'h04 || w[13:8] == 6'h08
      || w[13:7] == 7'h01;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("Error %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    if (resetn) begin
      check(acc, ea);
      check(8'(zf), 8'(ez));
      check(8'(hit), 8'(ehit));
      check(wr_o[15:8], ewr[15:8]);
      check(wr_o[7:0], ewr[7:0]);
      check(8'(rdy), 8'(clk_en));
      check(8'(ra), 8'(insn.word[6:0]));
    end
    if (!resetn) begin
      ea = 8'h00;
      ez = 1'b0;
      ehit = 1'b0;
      ewr = 16'h0000;
    end else if (clk_en) begin
      ehit = insn.valid && nh(insn.word);
      ewr = insn.valid ? nw(insn.word) : 16'h0000;
      ez = insn.valid ? nz(insn.word) : ez;
      ea = insn.valid ? nx(insn.word) : ea;
    end
    cyc++;
    if (cyc > 2200) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (corner[i]) begin
      @(posedge ref_clk);
      {clk_en, rnd, rd_data} <= corner[i];
    end
    // half the reads come back zero so the flag path is hit often;
    // a reset in mid-run must clear what the random ops built up
    repeat (2) begin
      repeat (1000) begin
        @(posedge ref_clk);
        {clk_en, rnd, rd_data} <= 21'($random(seed))
                                  & {13'h1FFF, {8{cyc[2]}}};
      end
      @(posedge ref_clk);
      resetn <= 1'b0;
      @(posedge ref_clk);
      resetn <= 1'b1;
    end
    tally_and_finish;
  end
endmodule
